// ### gpc_pkg.sv
`default_nettype none
package gpc_pkg;
    localparam int NPORT = 4;
    localparam int NPIN = 8;
    localparam int NGROUP = 4;
    localparam int PORT_STRIDE = 3;
    // Per-port registers
    localparam logic [7:0] ADR_PIN_BASE = 8'h20;
    localparam logic [7:0] ADR_DIR_BASE = 8'h21;
    localparam logic [7:0] ADR_LAT_BASE = 8'h22;
    // Interrupt and control registers
    localparam logic [7:0] ADR_MCU_CTRL = 8'h35;
    localparam logic [7:0] ADR_EXT_FLAG = 8'h3C;
    localparam logic [7:0] ADR_EXT_MASK = 8'h3D;
    localparam logic [7:0] ADR_SENSE = 8'h69;
    localparam logic [7:0] ADR_PIN_CHANGE_MASK_GROUP0 = 8'h6B;
    localparam logic [7:0] ADR_PIN_CHANGE_MASK_GROUP1 = 8'h6C;
    localparam logic [7:0] ADR_PIN_CHANGE_MASK_GROUP2 = 8'h6D;
    localparam logic [7:0] ADR_PIN_CHANGE_MASK_GROUP3 = 8'h73;
    // Field positions, valid masks, reset value and sense codes
    localparam int IRQ0_BIT = 0;
    localparam int PC_BIT_BASE = 4;
    localparam int PUD_BIT = 4;
    localparam logic [7:0] EXT_MASK_VALID = 8'hF1;
    localparam logic [7:0] PIN_CHANGE_MASK_GROUP3_VALID = 8'h7F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } gpc_sense_e;
endpackage
`default_nettype wire

// ### gpc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_sync #(
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic clk,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Capture stage read only by the second stage
    always_ff @(posedge clk) begin
        meta <= async_in;
        sync_out <= meta;
    end
endmodule // gpc_sync
`default_nettype wire

// ### gpc_port.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_port (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // CPU I/O access
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic io_bit_set,
    input wire logic io_bit_clr,
    input wire logic [2:0] io_bit_idx,
    output logic [7:0] io_rdata,
    // Interrupt handshake with the core
    input wire logic cpu_irq_global_en,
    input wire logic ext_irq0_ack,
    input wire logic [3:0] pc_irq_ack,
    output logic ext_irq0_req,
    output logic [3:0] pc_irq_req,
    // Pads
    input wire logic [31:0] pad_i,
    output logic [31:0] pad_o,
    output logic [31:0] pad_oe_n,
    output logic [31:0] pad_pu,
    input wire logic ext_irq0_line,
    // Alternate function overrides
    input wire logic [31:0] alt_en,
    input wire logic [31:0] alt_dir,
    input wire logic [31:0] alt_out
);
    logic [31:0] lat;
    logic [31:0] dir;
    logic [31:0] pin_lvl;
    logic [31:0] pin_prev;
    logic pin_primed;
    logic [3:0][7:0] pcmsk;
    logic [7:0] ext_mask;
    logic pullup_global_disable;
    gpc_pkg::gpc_sense_e sense;
    logic flag0;
    logic [3:0] pcif;
    logic irq0_lvl;
    logic irq0_prev;
    logic wr;
    logic [7:0] wmask;
    logic [7:0] wd;
    logic [7:0] next_rdata;
    logic irq0_ev;
    logic [3:0] pc_ev;
    logic level_mode;

    function automatic logic [7:0] port_addr(input logic [7:0] base, input int p);
        port_addr = base + 8'(gpc_pkg::PORT_STRIDE * p);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] m,
                                         input logic [7:0] d);
        merge = (old & ~m) | (d & m);
    endfunction

    // Pin and irq line synchronisers
    gpc_sync #(.WIDTH(32)) u_pin_sync (
        .clk(clk),
        .async_in(pad_i),
        .sync_out(pin_lvl)
    );

    gpc_sync #(.WIDTH(1)) u_irq_sync (
        .clk(clk),
        .async_in(ext_irq0_line),
        .sync_out(irq0_lvl)
    );

    // Bit operations become a masked write of one lane
    always_comb begin
        wr = io_we | io_bit_set | io_bit_clr;
        wmask = (io_bit_set | io_bit_clr) ? (8'h01 << io_bit_idx) : 8'hFF;
        wd = io_bit_set ? 8'hFF : (io_bit_clr ? 8'h00 : io_wdata);
    end

    // Port latch and direction registers
    for (genvar p = 0; p < gpc_pkg::NPORT; p++) begin : g_port
        always_ff @(posedge clk) begin
            if (srst) begin
                lat[p*8 +: 8] <= gpc_pkg::RESET_BYTE;
            end else if (wr && io_addr == port_addr(gpc_pkg::ADR_LAT_BASE, p)) begin
                lat[p*8 +: 8] <= merge(lat[p*8 +: 8], wmask, wd);
            end else if (wr && io_addr == port_addr(gpc_pkg::ADR_PIN_BASE, p)) begin
                lat[p*8 +: 8] <= lat[p*8 +: 8] ^ (wd & wmask);
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                dir[p*8 +: 8] <= gpc_pkg::RESET_BYTE;
            end else if (wr && io_addr == port_addr(gpc_pkg::ADR_DIR_BASE, p)) begin
                dir[p*8 +: 8] <= merge(dir[p*8 +: 8], wmask, wd);
            end
        end
    end

    // Pin-change masks
    always_ff @(posedge clk) begin
        if (srst) begin
            pcmsk <= '0;
        end else if (wr) begin
            if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP0) begin
                pcmsk[0] <= merge(pcmsk[0], wmask, wd);
            end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP1) begin
                pcmsk[1] <= merge(pcmsk[1], wmask, wd);
            end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP2) begin
                pcmsk[2] <= merge(pcmsk[2], wmask, wd);
            end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP3) begin
                pcmsk[3] <= merge(pcmsk[3], wmask, wd) & gpc_pkg::PIN_CHANGE_MASK_GROUP3_VALID;
            end
        end
    end

    // Enables, pull-up disable and sense control
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_mask <= gpc_pkg::RESET_BYTE;
            pullup_global_disable <= 1'b0;
            sense <= gpc_pkg::SENSE_LOW;
        end else if (wr) begin
            if (io_addr == gpc_pkg::ADR_EXT_MASK) begin
                ext_mask <= merge(ext_mask, wmask, wd) & gpc_pkg::EXT_MASK_VALID;
            end else if (io_addr == gpc_pkg::ADR_MCU_CTRL) begin
                // Only the disable bit lives here; other control bits must not set it
                pullup_global_disable <= wmask[gpc_pkg::PUD_BIT] ? wd[gpc_pkg::PUD_BIT] : pullup_global_disable;
            end else if (io_addr == gpc_pkg::ADR_SENSE) begin
                sense <= gpc_pkg::gpc_sense_e'({wmask[1] ? wd[1] : sense[1],
                                                wmask[0] ? wd[0] : sense[0]});
            end
        end
    end

    // Change detection; the first sample after reset only primes the history
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_primed <= 1'b0;
            pin_prev <= 32'h0000_0000;
            irq0_prev <= 1'b0;
        end else begin
            pin_primed <= 1'b1;
            pin_prev <= pin_lvl;
            irq0_prev <= irq0_lvl;
        end
    end

    always_comb begin
        level_mode = (sense == gpc_pkg::SENSE_LOW);
        irq0_ev = 1'b0;
        if (pin_primed) begin
            case (sense)
                gpc_pkg::SENSE_ANY: irq0_ev = irq0_lvl ^ irq0_prev;
                gpc_pkg::SENSE_FALL: irq0_ev = irq0_prev & ~irq0_lvl;
                gpc_pkg::SENSE_RISE: irq0_ev = irq0_lvl & ~irq0_prev;
                default: irq0_ev = 1'b0;
            endcase
        end
        for (int g = 0; g < gpc_pkg::NGROUP; g++) begin
            // Mask bit and group enable must both be set
            pc_ev[g] = pin_primed && ext_mask[gpc_pkg::PC_BIT_BASE + g]
                       && |((pin_lvl[g*8 +: 8] ^ pin_prev[g*8 +: 8]) & pcmsk[g]);
        end
    end

    // Flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            flag0 <= 1'b0;
        end else if (level_mode) begin
            flag0 <= 1'b0;
        end else if (irq0_ev) begin
            flag0 <= 1'b1;
        end else if (ext_irq0_ack
                     || (wr && io_addr == gpc_pkg::ADR_EXT_FLAG && wd[0] && wmask[0])) begin
            flag0 <= 1'b0;
        end
    end

    for (genvar g = 0; g < gpc_pkg::NGROUP; g++) begin : g_pcif
        always_ff @(posedge clk) begin
            if (srst) begin
                pcif[g] <= 1'b0;
            end else if (pc_ev[g]) begin
                pcif[g] <= 1'b1;
            end else if (pc_irq_ack[g] || (wr && io_addr == gpc_pkg::ADR_EXT_FLAG
                         && wd[gpc_pkg::PC_BIT_BASE + g] && wmask[gpc_pkg::PC_BIT_BASE + g])) begin
                pcif[g] <= 1'b0;
            end
        end
    end

    // Requests to the core
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_irq0_req <= 1'b0;
            pc_irq_req <= 4'h0;
        end else begin
            // Level mode requests straight from the line, as the flag stays clear
            ext_irq0_req <= cpu_irq_global_en && ext_mask[gpc_pkg::IRQ0_BIT]
                            && (level_mode ? ~irq0_lvl : flag0);
            pc_irq_req <= {4{cpu_irq_global_en}} & ext_mask[7:4] & pcif;
        end
    end

    // Read data, registered
    always_comb begin
        next_rdata = 8'h00;
        if (io_addr == gpc_pkg::ADR_EXT_FLAG) begin
            next_rdata = {pcif, 3'h0, flag0};
        end else if (io_addr == gpc_pkg::ADR_EXT_MASK) begin
            next_rdata = ext_mask;
        end else if (io_addr == gpc_pkg::ADR_MCU_CTRL) begin
            next_rdata = 8'({7'h00, pullup_global_disable} << gpc_pkg::PUD_BIT);
        end else if (io_addr == gpc_pkg::ADR_SENSE) begin
            next_rdata = {6'h00, sense};
        end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP0) begin
            next_rdata = pcmsk[0];
        end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP1) begin
            next_rdata = pcmsk[1];
        end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP2) begin
            next_rdata = pcmsk[2];
        end else if (io_addr == gpc_pkg::ADR_PIN_CHANGE_MASK_GROUP3) begin
            next_rdata = pcmsk[3];
        end else begin
            for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                if (io_addr == port_addr(gpc_pkg::ADR_PIN_BASE, p)) begin
                    next_rdata = pin_lvl[p*8 +: 8];
                end else if (io_addr == port_addr(gpc_pkg::ADR_DIR_BASE, p)) begin
                    next_rdata = dir[p*8 +: 8];
                end else if (io_addr == port_addr(gpc_pkg::ADR_LAT_BASE, p)) begin
                    next_rdata = lat[p*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            io_rdata <= 8'h00;
        end else if (io_re) begin
            io_rdata <= next_rdata;
        end
    end

    // Pad drivers; reset acts without a clock edge so pins float at once
    for (genvar n = 0; n < 32; n++) begin : g_pad
        logic eff_dir;
        logic eff_out;
        assign eff_dir = alt_en[n] ? alt_dir[n] : dir[n];
        assign eff_out = alt_en[n] ? alt_out[n] : lat[n];

        always_ff @(posedge clk or posedge srst) begin
            if (srst) begin
                pad_oe_n[n] <= 1'b1;
                pad_o[n] <= 1'b0;
                pad_pu[n] <= 1'b0;
            end else begin
                pad_oe_n[n] <= ~eff_dir;
                pad_o[n] <= eff_out;
                pad_pu[n] <= ~eff_dir & lat[n] & ~pullup_global_disable & ~alt_en[n];
            end
        end
    end

    // Checks
    a_irq0_edge_set: assert property (@(posedge clk) disable iff (srst)
        irq0_ev && !level_mode |=> flag0)
        else $error("irq0 flag not set after edge");

    a_irq0_level_clr: assert property (@(posedge clk) disable iff (srst)
        level_mode |=> !flag0)
        else $error("irq0 flag set in level mode");

    a_irq0_ack_clr: assert property (@(posedge clk) disable iff (srst)
        ext_irq0_ack && !irq0_ev |=> !flag0)
        else $error("irq0 flag survived acknowledge");

    a_irq0_req_out: assert property (@(posedge clk) disable iff (srst)
        cpu_irq_global_en && ext_mask[0] && flag0 && !level_mode |=> ext_irq0_req)
        else $error("irq0 request missing");

    a_pc_group_set: assert property (@(posedge clk) disable iff (srst)
        pc_ev[2] |=> pcif[2])
        else $error("group flag not set on armed change");

    a_msk3_top_zero: assert property (@(posedge clk) disable iff (srst)
        pcmsk[3][7] == 1'b0)
        else $error("group 3 mask bit 7 set");

    a_dir_bit_only: assert property (@(posedge clk) disable iff (srst)
        io_bit_set && !io_we && io_addr == gpc_pkg::ADR_DIR_BASE
        |=> dir[7:0] == ($past(dir[7:0]) | $past(wmask)))
        else $error("bit set disturbed other direction bits");

    a_pin_toggle_lat: assert property (@(posedge clk) disable iff (srst)
        io_we && !io_bit_set && !io_bit_clr && io_addr == gpc_pkg::ADR_PIN_BASE
        |=> lat[7:0] == ($past(lat[7:0]) ^ $past(io_wdata)))
        else $error("input register write did not toggle latch");

    a_pud_kills_pu: assert property (@(posedge clk) disable iff (srst)
        pullup_global_disable |=> pad_pu == 32'h0000_0000)
        else $error("pull-up on while globally disabled");

    a_out_drive: assert property (@(posedge clk) disable iff (srst)
        dir[0] && !alt_en[0] |=> !pad_oe_n[0] && pad_o[0] == $past(lat[0]))
        else $error("output pin not driving latch value");

    a_input_sync: assert property (@(posedge clk) disable iff (srst)
        ##2 pin_lvl == $past(pad_i, 2))
        else $error("pin level not two cycles behind pad");

    a_pc_req_out: assert property (@(posedge clk) disable iff (srst)
        cpu_irq_global_en && ext_mask[4] && pcif[0] |=> pc_irq_req[0])
        else $error("group 0 request missing");
endmodule // gpc_port
`default_nettype wire

// ### gpc_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_pad_model (
    // Clock
    input wire logic clk,
    // Device side of the pads
    input wire logic [31:0] pad_o,
    input wire logic [31:0] pad_oe_n,
    input wire logic [31:0] pad_pu,
    // Board drivers
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    // Wire level seen by the device
    output logic [31:0] pad_i
);
    logic [31:0] last;
    always_ff @(posedge clk) begin
        last <= pad_i;
    end
    // Undriven pins without pull-up wander, so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!pad_oe_n[i]) pad_i[i] = pad_o[i];
            else if (ext_en[i]) pad_i[i] = ext_val[i];
            else if (pad_pu[i]) pad_i[i] = 1'b1;
            else pad_i[i] = ~last[i];
        end
    end
endmodule // gpc_pad_model
`default_nettype wire

// ### tb_gpio_port_with_pin_change_masks.sv
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_port_with_pin_change_masks;
    logic clk = 0, srst = 1, io_we = 0, io_re = 0, io_bit_set = 0, io_bit_clr = 0;
    logic [7:0] io_addr = 0, io_wdata = 0, io_rdata;
    logic [2:0] io_bit_idx = 0;
    logic gie = 0, ack0 = 0, req0, line = 0;
    logic [3:0] pc_ack = 0, pc_req;
    logic [31:0] pad_i, pad_o, pad_oe_n, pad_pu, alt_en = 0, alt_dir = 0, alt_out = 0;
    logic [31:0] ext_en = 32'hFFFFFFFF, ext_val = 0;
    int failures = 0, compares = 0, cycles = 0;
    gpc_port uut (.clk(clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr),
        .io_bit_idx(io_bit_idx), .io_rdata(io_rdata), .cpu_irq_global_en(gie),
        .ext_irq0_ack(ack0), .pc_irq_ack(pc_ack), .ext_irq0_req(req0), .pc_irq_req(pc_req),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pad_pu(pad_pu),
        .ext_irq0_line(line), .alt_en(alt_en), .alt_dir(alt_dir), .alt_out(alt_out));
    gpc_pad_model pads (.clk(clk), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pad_pu(pad_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_we = 1;
        @(negedge clk);
        io_we = 0;
    endtask
    task automatic bop(input logic [7:0] a, input logic [2:0] idx, input logic set);
        @(negedge clk);
        io_addr = a;
        io_bit_idx = idx;
        io_bit_set = set;
        io_bit_clr = !set;
        @(negedge clk);
        io_bit_set = 0;
        io_bit_clr = 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        io_addr = a;
        io_re = 1;
        @(negedge clk);
        io_re = 0;
        chk(io_rdata, exp);
    endtask
    task automatic t_masks();
        logic [7:0] adr [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};
        logic [7:0] exp [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F};
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], 8'hFF);
            rchk(adr[i], exp[i]);
            wr(adr[i], 8'h00);
        end
        wr(8'h50, 8'hFF);
        rchk(8'h50, 8'h00);
        $display("test masks done");
    endtask
    task automatic t_drive();
        ext_en = 32'hFFFFFFF0;
        wr(8'h21, 8'h0F);
        wr(8'h22, 8'h05);
        @(negedge clk);
        chk(pad_oe_n[7:0], 8'hF0);
        chk(pad_o[3:0], 4'h5);
        repeat (3) @(negedge clk);
        rchk(8'h20, 8'h05);
        wr(8'h20, 8'h03);
        rchk(8'h22, 8'h06);
        rchk(8'h21, 8'h0F);
        bop(8'h21, 3'd6, 1'b1);
        rchk(8'h21, 8'h4F);
        bop(8'h22, 3'd1, 1'b0);
        rchk(8'h22, 8'h04);
        bop(8'h20, 3'd0, 1'b1);
        rchk(8'h22, 8'h05);
        $display("test drive done");
    endtask
    task automatic t_pull();
        ext_en[15:8] = 8'h00;
        wr(8'h24, 8'h0F);
        wr(8'h25, 8'hFF);
        @(negedge clk);
        chk(pad_pu[15:8], 8'hF0);
        wr(8'h35, 8'h10);
        @(negedge clk);
        chk(pad_pu, 32'h0);
        wr(8'h35, 8'hEF);
        rchk(8'h35, 8'h00);
        alt_en[12] = 1;
        alt_dir[12] = 1;
        repeat (2) @(negedge clk);
        chk(pad_oe_n[15:8], 8'hE0);
        chk(pad_pu[15:8], 8'hE0);
        chk(pad_o[12:8], 5'h0F);
        $display("test pull done");
    endtask
    task automatic t_irq0();
        wr(8'h69, 8'h03);
        wr(8'h3D, 8'h01);
        wr(8'h3C, 8'hF1);
        line = 1;
        repeat (6) @(negedge clk);
        chk(req0, 1'b0);
        rchk(8'h3C, 8'h01);
        gie = 1;
        repeat (3) if (req0 !== 1'b1) @(negedge clk);
        chk(req0, 1'b1);
        ack0 = 1;
        @(negedge clk);
        ack0 = 0;
        repeat (2) @(negedge clk);
        chk(req0, 1'b0);
        line = 0;
        repeat (4) @(negedge clk);
        line = 1;
        repeat (5) @(negedge clk);
        rchk(8'h3C, 8'h01);
        wr(8'h3C, 8'h01);
        rchk(8'h3C, 8'h00);
        wr(8'h69, 8'h00);
        line = 0;
        repeat (5) @(negedge clk);
        rchk(8'h3C, 8'h00);
        chk(req0, 1'b1);
        wr(8'h69, 8'h02);
        line = 1;
        repeat (5) @(negedge clk);
        rchk(8'h3C, 8'h00);
        line = 0;
        repeat (5) @(negedge clk);
        rchk(8'h3C, 8'h01);
        wr(8'h69, 8'h01);
        wr(8'h3C, 8'h01);
        line = 1;
        repeat (5) @(negedge clk);
        rchk(8'h3C, 8'h01);
        wr(8'h3D, 8'h00);
        $display("test irq0 done");
    endtask
    task automatic t_pc();
        wr(8'h3C, 8'hF1);
        wr(8'h6D, 8'h01);
        wr(8'h3D, 8'h40);
        ext_val[17] = 1;
        repeat (8) @(negedge clk);
        chk(pc_req, 4'h0);
        ext_val[16] = 1;
        repeat (10) if (pc_req[2] !== 1'b1) @(negedge clk);
        chk(pc_req, 4'h4);
        pc_ack = 4'h4;
        @(negedge clk);
        pc_ack = 4'h0;
        repeat (2) @(negedge clk);
        chk(pc_req, 4'h0);
        ext_val[16] = 0;
        repeat (6) @(negedge clk);
        rchk(8'h3C, 8'h40);
        wr(8'h3C, 8'h40);
        rchk(8'h3C, 8'h00);
        wr(8'h6B, 8'h01);
        wr(8'h3D, 8'h10);
        wr(8'h20, 8'h01);
        repeat (6) @(negedge clk);
        rchk(8'h3C, 8'h10);
        chk(pc_req, 4'h1);
        wr(8'h3C, 8'h10);
        rchk(8'h3C, 8'h00);
        $display("test pin change done");
    endtask
    task automatic t_reset();
        @(negedge clk);
        srst = 1;
        #1;
        chk(pad_oe_n, 32'hFFFFFFFF);
        chk(pad_pu, 32'h0);
        repeat (3) @(negedge clk);
        srst = 0;
        rchk(8'h21, 8'h00);
        rchk(8'h22, 8'h00);
        rchk(8'h6D, 8'h00);
        $display("test reset done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 0;
        t_masks();
        t_drive();
        t_pull();
        t_irq0();
        t_pc();
        t_reset();
        results();
    end
endmodule // tb_gpio_port_with_pin_change_masks
`default_nettype wire
